// *** hw/wdtc_cfg.svh ***
// Offsets, field positions, reset values and counts of the watchdog timeout control.
`ifndef WDTC_CFG_SVH
`define WDTC_CFG_SVH

// Register offsets on the plain register port.
`define WDTC_OFS_CTRL       4'h0
`define WDTC_OFS_STAT       4'h1
`define WDTC_OFS_MASK       4'h2

// Control register field positions.
`define WDTC_SEL_MSB        7
`define WDTC_SEL_LSB        4
`define WDTC_IRQSEL_BIT     3
`define WDTC_FLAG_BIT       2
`define WDTC_ARM_BIT        1
`define WDTC_UNLOCK_BIT     0

// Status and mask bit positions.
`define WDTC_ST_EXP_IRQ     0
`define WDTC_ST_EXP_RST     1
`define WDTC_ST_REFUSED     2

// Reset values.
`define WDTC_CTRL_RST       8'h00
`define WDTC_STAT_RST       3'h0
`define WDTC_MASK_RST       3'h1

// Timeout select codes.
`define WDTC_SEL_MAX_PERIOD 4'h7
`define WDTC_SEL_IMMEDIATE  4'h8

// Reference ticks in the shortest period, and the reference rate in Hz.
`define WDTC_BASE_TICKS     17'h00200
`define WDTC_REF_HZ         32768

`endif

// *** hw/wdtc_pkg.sv ***
// Types shared by the watchdog timeout control files.
package wdtc_pkg;

    // Control register layout, most significant field first.
    typedef struct packed {
        logic [3:0] timeout_select;
        logic       timeout_irq_select;
        logic       timeout_flag;
        logic       watchdog_arm;
        logic       write_unlock;
    } wdtc_ctrl_t;

    // One request of the register port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } wdtc_bus_req_t;

    // Watchdog sequencer states.
    typedef enum logic [1:0] {
        WDTC_ST_OFF,
        WDTC_ST_RUN,
        WDTC_ST_FIRE
    } wdtc_state_t;

endpackage

// *** hw/wdtc_ref_tick.sv ***
// Synchroniser and edge detector for the reference clock pin.
`timescale 1ns/100ps
`default_nettype none
module wdtc_ref_tick (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ref_clk_pin,
    output var  logic tick
);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic       stable_r;
    logic       stable_nxt;
    logic       tick_r;
    logic       tick_nxt;

    // The first stage only feeds the second; a change counts once stages two and three agree.
    always_comb
    begin
        sync_nxt   = {sync_r[1:0], ref_clk_pin};
        stable_nxt = stable_r;
        tick_nxt   = 1'b0;
        if (sync_r[1] == sync_r[2] && sync_r[2] != stable_r)
        begin
            stable_nxt = sync_r[2];
            tick_nxt   = sync_r[2];     // Rising edge of the reference clock.
        end
    end

    // Registers of the synchroniser.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_r   <= 3'h0;
            stable_r <= 1'b0;
            tick_r   <= 1'b0;
        end
        else
        begin
            sync_r   <= sync_nxt;
            stable_r <= stable_nxt;
            tick_r   <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule
`default_nettype wire

// *** hw/wdtc_top.sv ***
// Watchdog timeout control with its register port and interrupt status.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "wdtc_cfg.svh"

//
// How it works
// RULE1 - Select codes map to periods, 8 resets now.
// RULE2 - Interrupt select turns expiry into interrupt.
// RULE3 - Watchdog interrupt ignores the global enable.
// RULE4 - Watchdog interrupt always has high priority.
// RULE5 - Interrupt mode works as a periodic timer.
// RULE6 - Every expiry sets the timeout flag.
// RULE7 - Flag clears by written zero or reset.
// RULE8 - Own watchdog reset keeps the flag set.
// RULE9 - Period is two-to-select times 512 ticks.
// RULE10 - Writing arm one restarts; silence means expiry.
// RULE11 - Control write needs unlock on previous access.
// RULE12 - After interrupt expiry the count restarts.
module wdtc_top #(
    parameter logic [16:0] BASE_TICKS = `WDTC_BASE_TICKS
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire wdtc_pkg::wdtc_bus_req_t bus_req,
    output var  logic [7:0]             rdata,
    input  wire logic                   ref_clk_pin,
    input  wire logic                   global_irq_enable,
    output var  logic                   sys_reset_out,
    output var  logic                   irq,
    output var  logic                   wdt_irq_high_prio,
    output var  logic                   cpu_irq_req
);
    import wdtc_pkg::*;

    // Last count of a period for a select code.
    function automatic logic [16:0] wdtc_last(input logic [3:0] sel, input logic [16:0] base);
        return 17'((base << sel[2:0]) - 17'h00001);
    endfunction

    // True for select codes that carry a period.
    function automatic logic wdtc_has_period(input logic [3:0] sel);
        return sel <= `WDTC_SEL_MAX_PERIOD;
    endfunction

    // Register file state.
    wdtc_ctrl_t  ctrl_r;
    wdtc_ctrl_t  ctrl_nxt;
    logic [2:0]  status_r;
    logic [2:0]  status_nxt;
    logic [2:0]  mask_r;
    logic [2:0]  mask_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;

    // Sequencer state.
    wdtc_state_t state_r;
    wdtc_state_t state_nxt;
    logic [16:0] count_r;
    logic [16:0] count_nxt;
    logic        sys_reset_r;
    logic        sys_reset_nxt;

    // Decoded accesses and events.
    wdtc_ctrl_t  new_ctrl;
    logic        ctrl_wr;
    logic        wr_take;
    logic        wr_refused;
    logic        rearm;
    logic        immediate;
    logic        tick;
    logic        period_ok;
    logic        expire;
    logic        irq_evt;
    logic        fire_evt;
    logic [16:0] last;

    // Reference clock ticks, synchronised to clk.
    wdtc_ref_tick u_ref_tick (
        .clk         (clk),
        .reset       (reset),
        .ref_clk_pin (ref_clk_pin),
        .tick        (tick)
    );

    // Decode of control writes and of the unlock state.
    always_comb
    begin
        new_ctrl   = wdtc_ctrl_t'(bus_req.wdata);
        ctrl_wr    = bus_req.wr && (bus_req.addr == `WDTC_OFS_CTRL);
        wr_take    = ctrl_wr && ctrl_r.write_unlock;                      // see RULE11
        wr_refused = ctrl_wr && !ctrl_r.write_unlock && !new_ctrl.write_unlock; // see RULE11
        rearm      = wr_take && new_ctrl.watchdog_arm;                    // see RULE10
        immediate  = wr_take && (new_ctrl.timeout_select == `WDTC_SEL_IMMEDIATE); // see RULE1
    end

    // Expiry detection on the current period.
    always_comb
    begin
        last      = wdtc_last(ctrl_r.timeout_select, BASE_TICKS);        // see RULE9
        period_ok = wdtc_has_period(ctrl_r.timeout_select);              // see RULE1
        expire    = (state_r == WDTC_ST_RUN) && period_ok && tick && (count_r >= last) && !rearm;
        irq_evt   = expire && ctrl_r.timeout_irq_select;                 // see RULE2
        fire_evt  = immediate || (expire && !ctrl_r.timeout_irq_select); // see RULE2
    end

    // Next values of the control register.
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr)
        begin
            if (ctrl_r.write_unlock)
            begin
                ctrl_nxt              = new_ctrl;
                ctrl_nxt.write_unlock = 1'b0;
                // Writing one leaves the flag alone; only a zero clears it.
                ctrl_nxt.timeout_flag = ctrl_r.timeout_flag & new_ctrl.timeout_flag; // see RULE7
            end
            else
            begin
                ctrl_nxt.write_unlock = new_ctrl.write_unlock;          // see RULE11
            end
        end
        else if (bus_req.wr || bus_req.rd)
        begin
            ctrl_nxt.write_unlock = 1'b0;                               // see RULE11
        end
        // Events come last so that a set beats a clear in the same cycle.
        if (fire_evt)
        begin
            ctrl_nxt.timeout_flag = 1'b1;                               // see RULE6
            ctrl_nxt.watchdog_arm = 1'b0;
        end
        if (irq_evt)
        begin
            ctrl_nxt.timeout_flag = 1'b1;                               // see RULE6
        end
    end

    // Next values of status, mask and read data.
    always_comb
    begin
        status_nxt = status_r;
        mask_nxt   = mask_r;
        rdata_nxt  = 8'h00;
        if (bus_req.rd && (bus_req.addr == `WDTC_OFS_STAT))
        begin
            status_nxt = 3'h0;
        end
        if (irq_evt)
        begin
            status_nxt[`WDTC_ST_EXP_IRQ] = 1'b1;
        end
        if (fire_evt)
        begin
            status_nxt[`WDTC_ST_EXP_RST] = 1'b1;
        end
        if (wr_refused)
        begin
            status_nxt[`WDTC_ST_REFUSED] = 1'b1;
        end
        if (bus_req.wr && (bus_req.addr == `WDTC_OFS_MASK))
        begin
            mask_nxt = bus_req.wdata[2:0];
        end
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `WDTC_OFS_CTRL: rdata_nxt = ctrl_r;
                `WDTC_OFS_STAT: rdata_nxt = {5'h00, status_r};
                `WDTC_OFS_MASK: rdata_nxt = {5'h00, mask_r};
                default:        rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register file registers; besides a written zero, only the external reset clears the flag.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_r   <= wdtc_ctrl_t'(`WDTC_CTRL_RST);                   // see RULE7
            status_r <= `WDTC_STAT_RST;
            mask_r   <= `WDTC_MASK_RST;
            rdata_r  <= 8'h00;
        end
        else
        begin
            ctrl_r   <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // Next values of the sequencer and its counter.
    always_comb
    begin
        state_nxt     = state_r;
        count_nxt     = count_r;
        sys_reset_nxt = 1'b0;
        case (state_r)
            WDTC_ST_OFF:
            begin
                count_nxt = 17'h00000;
                if (immediate)
                begin
                    state_nxt = WDTC_ST_FIRE;                           // see RULE1
                end
                else if (rearm)
                begin
                    state_nxt = WDTC_ST_RUN;                            // see RULE10
                end
            end
            WDTC_ST_RUN:
            begin
                if (fire_evt)
                begin
                    state_nxt = WDTC_ST_FIRE;                           // see RULE10
                end
                else if (rearm)
                begin
                    count_nxt = 17'h00000;                              // see RULE10
                end
                else if (!ctrl_nxt.watchdog_arm)
                begin
                    state_nxt = WDTC_ST_OFF;
                end
                else if (irq_evt)                                       // see RULE5
                begin
                    count_nxt = 17'h00000;                              // see RULE12
                end
                else if (tick && period_ok)
                begin
                    count_nxt = count_r + 17'h00001;
                end
            end
            WDTC_ST_FIRE:
            begin
                // Reset pulse lasts one cycle; the flag survives it.
                count_nxt = 17'h00000;
                state_nxt = WDTC_ST_OFF;                                // see RULE8
            end
            default:
            begin
                state_nxt = WDTC_ST_OFF;
                count_nxt = 17'h00000;
            end
        endcase
        if (state_nxt == WDTC_ST_FIRE)
        begin
            sys_reset_nxt = 1'b1;                                       // see RULE2
        end
    end

    // Sequencer registers.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r     <= WDTC_ST_OFF;
            count_r     <= 17'h00000;
            sys_reset_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            count_r     <= count_nxt;
            sys_reset_r <= sys_reset_nxt;
        end
    end

    // Outputs: the watchdog interrupt stays high priority and skips the global enable.
    assign rdata             = rdata_r;
    assign sys_reset_out     = sys_reset_r;
    assign irq               = |(status_r & mask_r);
    assign wdt_irq_high_prio = status_r[`WDTC_ST_EXP_IRQ] & mask_r[`WDTC_ST_EXP_IRQ]; // see RULE4
    assign cpu_irq_req       = wdt_irq_high_prio |                      // see RULE3
                               (global_irq_enable & |(status_r[2:1] & mask_r[2:1])); // see RULE3
endmodule
`default_nettype wire

// *** dv/wdtc_top_props.sv ***
// Port assertions of the watchdog timeout control.
`timescale 1ns/100ps
`default_nettype none
module wdtc_top_props (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire wdtc_pkg::wdtc_bus_req_t bus_req,
    input wire logic [7:0]              rdata,
    input wire logic                    ref_clk_pin,
    input wire logic                    global_irq_enable,
    input wire logic                    sys_reset_out,
    input wire logic                    irq,
    input wire logic                    wdt_irq_high_prio,
    input wire logic                    cpu_irq_req
);
    import wdtc_pkg::*;
    logic c_wr;
    logic idle;

    // Control writes and idle cycles of the register port.
    assign c_wr = bus_req.wr && bus_req.addr == 4'h0;
    assign idle = !bus_req.wr && !bus_req.rd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    prio_path_a: assert property (wdt_irq_high_prio |-> cpu_irq_req)
        else $error("watchdog interrupt not forwarded");
    prio_level_a: assert property (wdt_irq_high_prio |-> irq)
        else $error("watchdog interrupt missing on irq");
    gate_off_a: assert property (!global_irq_enable |-> cpu_irq_req == wdt_irq_high_prio)
        else $error("gated request leaked");
    rst_pulse_a: assert property (sys_reset_out |=> !sys_reset_out)
        else $error("reset request longer than one cycle");
    imm_reset_a: assert property (bus_req.rd ##1 idle ##1 c_wr && bus_req.wdata == 8'h01 ##1 idle
        ##1 c_wr && bus_req.wdata[7:4] == 4'h8 |-> ##[1:2] sys_reset_out)
        else $error("immediate reset missing");
    mask_gate_a: assert property (bus_req.wr && bus_req.addr == 4'h2 && !bus_req.wdata[0]
        |=> !wdt_irq_high_prio)
        else $error("masked watchdog interrupt raised");
    rdata_idle_a: assert property (!bus_req.rd |=> rdata == 8'h00)
        else $error("read data without read");
    unmapped_a: assert property (bus_req.rd && bus_req.addr > 4'h2 |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // Main scenarios reached.
    cover property (sys_reset_out);
    cover property (wdt_irq_high_prio && !global_irq_enable);
    cover property (irq && !wdt_irq_high_prio);
endmodule

bind wdtc_top wdtc_top_props u_wdtc_top_props (
    .clk              (clk),
    .reset            (reset),
    .bus_req          (bus_req),
    .rdata            (rdata),
    .ref_clk_pin      (ref_clk_pin),
    .global_irq_enable(global_irq_enable),
    .sys_reset_out    (sys_reset_out),
    .irq              (irq),
    .wdt_irq_high_prio(wdt_irq_high_prio),
    .cpu_irq_req      (cpu_irq_req)
);
`default_nettype wire

// *** dv/tb_wdtc_top.sv ***
// Self-checking testbench of the watchdog timeout control.
`timescale 1ns/100ps
`default_nettype none
module tb_wdtc_top;
    import wdtc_pkg::*;
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    wdtc_bus_req_t bus_req = '0;
    logic          ref_clk_pin = 1'b0;
    logic          global_irq_enable = 1'b0;
    logic [7:0]    rdata;
    logic          sys_reset_out;
    logic          irq;
    logic          wdt_irq_high_prio;
    logic          cpu_irq_req;
    int            mismatches = 0;
    int            checks_done = 0;
    int            n;

    // Clock of 25 ns period.
    always #12.5 clk = ~clk;

    // Reference pin with a period of 16 clocks keeps the timeouts short.
    always
    begin
        repeat (8) @(posedge clk);
        ref_clk_pin <= ~ref_clk_pin;
    end

    wdtc_top #(.BASE_TICKS(17'h00004)) u_wdtc_top (
        .clk              (clk),
        .reset            (reset),
        .bus_req          (bus_req),
        .rdata            (rdata),
        .ref_clk_pin      (ref_clk_pin),
        .global_irq_enable(global_irq_enable),
        .sys_reset_out    (sys_reset_out),
        .irq              (irq),
        .wdt_irq_high_prio(wdt_irq_high_prio),
        .cpu_irq_req      (cpu_irq_req)
    );

    // Prints the verdict and ends the run.
    task results;
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One register access; returns at the edge that takes it.
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{w, !w, a, d};
        @(posedge clk);
        bus_req <= '0;
    endtask

    // Read and compare the data of the following cycle.
    task rd(input logic [3:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        #1;
        chk(16'(rdata), 16'(exp));
    endtask

    // Unlocked write of the control register.
    task ctrl_wr(input logic [7:0] d);
        acc(1'b1, 4'h0, 8'h01);
        acc(1'b1, 4'h0, d);
    endtask

    // Waits, bounded, for the reset request or the watchdog interrupt.
    task wait_ev(input logic rst);
        n = 0;
        #1;
        while (!(rst ? sys_reset_out === 1'b1 : wdt_irq_high_prio === 1'b1) && n < 20000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // Interrupt mode repeats at the period of each select code from 0 to 7.
    task t_periods;
        for (int s = 0; s < 8; s++)
        begin
            ctrl_wr({4'(s), 4'hA});
            wait_ev(1'b0);
            chk(16'(cpu_irq_req), 16'h0001);
            chk(16'(sys_reset_out), 16'h0000);
            rd(4'h1, 8'h01);
            wait_ev(1'b0);
            chk(16'(n + 2), 16'(64 << s));
            rd(4'h1, 8'h01);
        end
    endtask

    // Reset mode expiry keeps the flag until a zero is written.
    task t_reset_mode;
        ctrl_wr(8'h02);
        wait_ev(1'b1);
        chk(16'(sys_reset_out), 16'h0001);
        rd(4'h0, 8'h04);
        rd(4'h1, 8'h02);
        ctrl_wr(8'h00);
        rd(4'h0, 8'h00);
    endtask

    // Rewriting the arm bit in time holds the expiry off.
    task t_kick;
        ctrl_wr(8'h0A);
        repeat (4)
        begin
            repeat (30) @(posedge clk);
            ctrl_wr(8'h0A);
        end
        rd(4'h1, 8'h00);
        wait_ev(1'b0);
        rd(4'h1, 8'h01);
    endtask

    // A locked control write is refused and raises the status interrupt.
    task t_refused;
        ctrl_wr(8'h00);
        acc(1'b1, 4'h2, 8'h07);
        acc(1'b0, 4'h1, 8'h00);
        acc(1'b1, 4'h0, 8'h80);
        #1;
        chk(16'(irq), 16'h0001);
        chk(16'(cpu_irq_req), 16'h0000);
        chk(16'(sys_reset_out), 16'h0000);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        #1;
        chk(16'(cpu_irq_req), 16'h0001);
        rd(4'h1, 8'h04);
        chk(16'(irq), 16'h0000);
        rd(4'h0, 8'h00);
    endtask

    // Immediate reset code, then a reserved code that never expires.
    task t_codes;
        rd(4'h3, 8'h00);
        ctrl_wr(8'h80);
        wait_ev(1'b1);
        chk(16'(n), 16'h0000);
        rd(4'h1, 8'h02);
        rd(4'h0, 8'h84);
        ctrl_wr(8'h9A);
        repeat (300) @(posedge clk);
        rd(4'h1, 8'h00);
    endtask

    // A masked expiry still sets its status bit.
    task t_mask;
        acc(1'b1, 4'h2, 8'h06);
        ctrl_wr(8'h0A);
        repeat (150) @(posedge clk);
        #1;
        chk(16'(irq), 16'h0000);
        chk(16'(wdt_irq_high_prio), 16'h0000);
        rd(4'h1, 8'h01);
    endtask

    // An external reset in mid-run clears the flag that a watchdog reset left set.
    task t_hw_reset;
        ctrl_wr(8'h80);
        rd(4'h0, 8'h84);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h01);
    endtask

    // Main sequence after two cycles of reset.
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_periods;
        t_reset_mode;
        t_kick;
        t_refused;
        t_codes;
        t_mask;
        t_hw_reset;
        results;
    end

    // Watchdog against a hang.
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        results;
    end
endmodule
`default_nettype wire
